// *** lsar_host_model.sv ***
// Host microprocessor model: write and read cycles on the bank's register port.
// Assumes a read is answered by an rvalid pulse one cycle after the read edge.
`timescale 1ns/1ps
module lsar_host_model (
    input  wire logic                     i_sys_clk,
    input  wire logic [7:0]               i_host_rdata,
    input  wire logic                     i_host_rvalid,
    output lsar_pkg::lsar_host_req_t      o_host_req
);
    import lsar_pkg::*;
    initial o_host_req = '0;
    // A released bus shows inverted values so stale address or data never looks valid.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_sys_clk);
        #1;
        o_host_req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: (addr == OFF_SHAPE) ? {3'h0, data[4:0]} : data};
        @(posedge i_sys_clk);
        #1;
        o_host_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
    endtask : wr
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_sys_clk);
        #1;
        o_host_req = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: o_host_req.wdata};
        @(posedge i_sys_clk);
        #1;
        o_host_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~o_host_req.wdata};
        data = i_host_rvalid ? i_host_rdata : 8'hxx;
    endtask : rd
endmodule : lsar_host_model

// *** lsar_pkg.sv ***
// Package for the line shape and alarm register bank: register offsets, field layout and carrier types.
// Assumes an eight-bit host register port on the same clock as the channel line logic.
package lsar_pkg;

    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned CHAN_W    = 3;
    localparam int unsigned PIDX_W    = 5;
    localparam int unsigned SAMPLE_W  = 7;
    localparam int unsigned SAMPLES   = 24;
    localparam int unsigned CHANNELS  = 8;

    localparam logic [ADDR_W-1:0] OFF_SHAPE_CHAN = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SHAPE      = 8'h11;
    localparam logic [ADDR_W-1:0] OFF_DRV_DIS    = 8'h12;
    localparam logic [ADDR_W-1:0] OFF_ALM_STAT   = 8'h13;
    localparam logic [ADDR_W-1:0] OFF_ALM_EN     = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_ALM_INT    = 8'h15;
    localparam logic [ADDR_W-1:0] OFF_BCAST      = 8'h16;
    localparam logic [ADDR_W-1:0] OFF_PHASE_ADDR = 8'h17;
    localparam logic [ADDR_W-1:0] OFF_PHASE_DATA = 8'h18;

    localparam logic [DATA_W-1:0] RESET_VAL      = 8'h00;

    // Line shape register layout.
    localparam int unsigned SHAPE_FIELD_LSB = 0;
    localparam int unsigned SHAPE_FIELD_W   = 4;
    localparam int unsigned INT_MATCH_BIT   = 4;
    localparam int unsigned SHAPE_STORE_W   = 5;

    // Phase address register layout.
    localparam int unsigned PA_IDX_LSB  = 0;
    localparam int unsigned PA_CHAN_LSB = 5;

    localparam logic [SHAPE_FIELD_W-1:0] SHAPE_CODE_120 = 4'h0;
    localparam logic [SHAPE_FIELD_W-1:0] SHAPE_CODE_75  = 4'h8;
    localparam logic [SAMPLE_W-1:0]      SAMPLE_MAX_POS = 7'h3F;
    localparam logic [SAMPLE_W-1:0]      SAMPLE_MAX_NEG = 7'h40;

    typedef enum logic [1:0] {
        LSAR_SHAPE_120,
        LSAR_SHAPE_75,
        LSAR_SHAPE_UNDEF
    } lsar_shape_t;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lsar_host_req_t;

    typedef struct packed {
        lsar_shape_t shape;
        logic        internal_matching_select;
        logic        driver_highz;
    } lsar_chan_cfg_t;

endpackage : lsar_pkg

// *** lsar_regs.sv ***
// Line shape, transmit driver disable, alarm and custom waveform registers of an eight-channel line interface.
// Assumes the host strobes and the alarm levels come from logic on i_sys_clk, so no synchroniser is needed.
//
// How it works
// RULE1: Shape settings go to the selected channel.
// RULE2: Decode 0000 as 120 ohm, 1000 as 75.
// RULE3: Bit 4 picks internal or external matching.
// RULE4: Host writes zeros to bits seven to five.
// RULE5: Driver disable bit puts channel output high-Z.
// RULE6: Alarm status mirrors each receiver alarm.
// RULE7: Enable bits gate latching of alarm changes.
// RULE8: Alarm changes latch sticky until cleared.
// RULE9: Phase data written to every broadcast channel.
// RULE10: Phase address top bits pick channel.
// RULE11: Phase address low bits pick sample.
// RULE12: Every register clears to zero on reset. The waveform memory behind phase data is not reset here.
// RULE13: Reading interrupt status clears it and interrupt.
// RULE14: Samples are seven-bit two's complement values.
// RULE15: Interrupt low while any enabled bit set.
`timescale 1ns/1ps
module lsar_regs #(
    parameter int unsigned NUM_CH      = 8,
    parameter int unsigned NUM_SAMPLES = 24
) (
    input  wire logic                                      i_sys_clk,
    input  wire logic                                      i_rst,
    input  wire logic                                      i_clk_en,
    input  wire lsar_pkg::lsar_host_req_t                  i_host_req,
    output logic [lsar_pkg::DATA_W-1:0]                    o_host_rdata,
    output logic                                           o_host_rvalid,
    input  wire logic [NUM_CH-1:0]                         i_alarm,
    input  wire logic [lsar_pkg::PIDX_W-1:0]               i_line_sample_idx,
    output lsar_pkg::lsar_chan_cfg_t [NUM_CH-1:0]          o_chan_cfg,
    output logic [NUM_CH-1:0][lsar_pkg::SAMPLE_W-1:0]      o_line_sample,
    output logic                                           o_int_n
);
    import lsar_pkg::*;

    // Checked at elaboration, so an unusable build is refused before any cycle runs.
    if (NUM_CH < 1 || NUM_CH > CHANNELS) begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 8");
    end
    if (NUM_SAMPLES < 1 || NUM_SAMPLES > (1 << PIDX_W)) begin : g_bad_num_samples
        $error("NUM_SAMPLES must fit the five-bit sample index");
    end

    function automatic lsar_shape_t decode_shape(input logic [SHAPE_FIELD_W-1:0] code);
        lsar_shape_t s;
        s = LSAR_SHAPE_UNDEF;
        if (code == SHAPE_CODE_120) begin
            s = LSAR_SHAPE_120;
        end else if (code == SHAPE_CODE_75) begin
            s = LSAR_SHAPE_75;
        end
        return s;
    endfunction : decode_shape

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction : hit

    logic [CHAN_W-1:0]                   shape_channel_select_ff;
    logic [SHAPE_STORE_W-1:0]            shape_ff [NUM_CH];
    logic [NUM_CH-1:0]                   driver_highz_bits_ff;
    logic [NUM_CH-1:0]                   alarm_status_ff;
    logic [NUM_CH-1:0]                   alarm_enable_ff;
    logic [NUM_CH-1:0]                   alarm_change_bits_ff;
    logic [NUM_CH-1:0]                   broadcast_channel_mask_ff;
    logic [CHAN_W-1:0]                   phase_target_channel_ff;
    logic [PIDX_W-1:0]                   phase_sample_index_ff;
    logic [SAMPLE_W-1:0]                 wave_mem [NUM_CH][NUM_SAMPLES];
    logic [DATA_W-1:0]                   rdata_ff;
    logic                                rvalid_ff;
    logic                                int_n_ff;
    lsar_chan_cfg_t [NUM_CH-1:0]         cfg_ff;
    logic [NUM_CH-1:0][SAMPLE_W-1:0]     line_sample_ff;

    wire                      wr_en        = i_clk_en && i_host_req.wr;
    wire                      rd_en        = i_clk_en && i_host_req.rd;
    wire [ADDR_W-1:0]         addr         = i_host_req.addr;
    wire [DATA_W-1:0]         wdata        = i_host_req.wdata;
    wire                      wr_shape     = wr_en && hit(addr, OFF_SHAPE);
    wire                      wr_phase     = wr_en && hit(addr, OFF_PHASE_DATA);
    wire                      rd_int       = rd_en && hit(addr, OFF_ALM_INT);
    wire                      sel_in_range = 32'(shape_channel_select_ff) < NUM_CH;
    wire                      pidx_ok      = 32'(phase_sample_index_ff) < NUM_SAMPLES;
    wire                      tgt_ok       = 32'(phase_target_channel_ff) < NUM_CH;
    wire [NUM_CH-1:0]         alarm_change = i_alarm ^ alarm_status_ff;
    // Set wins over the read clear, so a change landing on the clearing read is kept.
    wire [NUM_CH-1:0]         alarm_set    = alarm_change & alarm_enable_ff;                       // [RULE7]
    wire [NUM_CH-1:0]         nxt_alarm_change_bits =
        (rd_int ? {NUM_CH{1'b0}} : alarm_change_bits_ff) | alarm_set;                              // [RULE8] [RULE13]
    wire                      nxt_int_n    = ~|(nxt_alarm_change_bits & alarm_enable_ff);          // [RULE15]
    wire [SHAPE_STORE_W-1:0]  sel_shape    = sel_in_range ? shape_ff[shape_channel_select_ff]
                                                          : SHAPE_STORE_W'(RESET_VAL);
    wire [SAMPLE_W-1:0]       sel_sample   = (pidx_ok && tgt_ok)
        ? wave_mem[phase_target_channel_ff][phase_sample_index_ff] : SAMPLE_W'(RESET_VAL);
    // A zero broadcast mask falls back to the channel named in the phase address.
    wire [NUM_CH-1:0]         phase_dest   = (|broadcast_channel_mask_ff) ? broadcast_channel_mask_ff
                                           : (tgt_ok ? NUM_CH'(1) << phase_target_channel_ff
                                                     : {NUM_CH{1'b0}});                            // [RULE9]

    logic [DATA_W-1:0] nxt_rdata;
    always_comb begin
        nxt_rdata = RESET_VAL;
        case (addr)
            OFF_SHAPE_CHAN: nxt_rdata = DATA_W'(shape_channel_select_ff);
            OFF_SHAPE:      nxt_rdata = DATA_W'(sel_shape);                                        // [RULE1]
            OFF_DRV_DIS:    nxt_rdata = DATA_W'(driver_highz_bits_ff);
            OFF_ALM_STAT:   nxt_rdata = DATA_W'(alarm_status_ff);                                  // [RULE6]
            OFF_ALM_EN:     nxt_rdata = DATA_W'(alarm_enable_ff);
            OFF_ALM_INT:    nxt_rdata = DATA_W'(alarm_change_bits_ff);
            OFF_BCAST:      nxt_rdata = DATA_W'(broadcast_channel_mask_ff);
            OFF_PHASE_ADDR: nxt_rdata = {phase_target_channel_ff, phase_sample_index_ff};
            OFF_PHASE_DATA: nxt_rdata = DATA_W'(sel_sample);
            default:        nxt_rdata = RESET_VAL;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin                                                                           // [RULE12]
            shape_channel_select_ff   <= CHAN_W'(RESET_VAL);
            driver_highz_bits_ff      <= NUM_CH'(RESET_VAL);
            alarm_status_ff           <= NUM_CH'(RESET_VAL);
            alarm_enable_ff           <= NUM_CH'(RESET_VAL);
            alarm_change_bits_ff      <= NUM_CH'(RESET_VAL);
            broadcast_channel_mask_ff <= NUM_CH'(RESET_VAL);
            phase_target_channel_ff   <= CHAN_W'(RESET_VAL);
            phase_sample_index_ff     <= PIDX_W'(RESET_VAL);
            rdata_ff                  <= RESET_VAL;
            rvalid_ff                 <= 1'b0;
            int_n_ff                  <= 1'b1;
        end else if (i_clk_en) begin
            alarm_status_ff      <= i_alarm;                                                       // [RULE6]
            alarm_change_bits_ff <= nxt_alarm_change_bits;                                         // [RULE8]
            int_n_ff             <= nxt_int_n;                                                     // [RULE15]
            rvalid_ff            <= rd_en;
            if (rd_en) begin
                rdata_ff <= nxt_rdata;
            end
            if (wr_en) begin
                case (addr)
                    OFF_SHAPE_CHAN: shape_channel_select_ff   <= wdata[CHAN_W-1:0];
                    OFF_DRV_DIS:    driver_highz_bits_ff      <= wdata[NUM_CH-1:0];
                    OFF_ALM_EN:     alarm_enable_ff           <= wdata[NUM_CH-1:0];
                    OFF_BCAST:      broadcast_channel_mask_ff <= wdata[NUM_CH-1:0];
                    OFF_PHASE_ADDR: begin
                        phase_target_channel_ff <= wdata[PA_CHAN_LSB +: CHAN_W];                   // [RULE10]
                        phase_sample_index_ff   <= wdata[PA_IDX_LSB +: PIDX_W];                    // [RULE11]
                    end
                    default: ;
                endcase
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            always_ff @(posedge i_sys_clk) begin
                if (i_rst) begin
                    shape_ff[ch] <= SHAPE_STORE_W'(RESET_VAL);                                     // [RULE12]
                    cfg_ff[ch]   <= '{shape: LSAR_SHAPE_120, internal_matching_select: 1'b0,
                                      driver_highz: 1'b0};
                end else if (i_clk_en) begin
                    // Reserved upper bits are dropped so a careless write cannot leak into them.
                    if (wr_shape && 32'(shape_channel_select_ff) == ch) begin
                        shape_ff[ch] <= wdata[SHAPE_STORE_W-1:0];                                  // [RULE1] [RULE4]
                    end
                    cfg_ff[ch].shape <= decode_shape(shape_ff[ch][SHAPE_FIELD_LSB +: SHAPE_FIELD_W]); // [RULE2]
                    cfg_ff[ch].internal_matching_select <= shape_ff[ch][INT_MATCH_BIT];            // [RULE3]
                    cfg_ff[ch].driver_highz <= driver_highz_bits_ff[ch];                           // [RULE5]
                end
            end

            // Waveform memory holds no reset; software reloads it after power-up.
            always_ff @(posedge i_sys_clk) begin
                if (i_clk_en) begin
                    if (wr_phase && pidx_ok && phase_dest[ch]) begin
                        wave_mem[ch][phase_sample_index_ff] <= wdata[SAMPLE_W-1:0];                // [RULE9] [RULE11] [RULE14]
                    end
                    if (32'(i_line_sample_idx) < NUM_SAMPLES) begin
                        line_sample_ff[ch] <= wave_mem[ch][i_line_sample_idx];
                    end else begin
                        line_sample_ff[ch] <= SAMPLE_W'(RESET_VAL);
                    end
                end
            end
        end
    endgenerate

    assign o_host_rdata  = rdata_ff;
    assign o_host_rvalid = rvalid_ff;
    assign o_chan_cfg    = cfg_ff;
    assign o_line_sample = line_sample_ff;
    assign o_int_n       = int_n_ff;

endmodule : lsar_regs

// *** lsar_regs_properties.sv ***
// Assertion checker for the line shape and alarm register bank, bound to the bank's ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module lsar_regs_properties #(
    parameter int unsigned NUM_CH      = 8,
    parameter int unsigned NUM_SAMPLES = 24
) (
    input wire logic                                       i_sys_clk,
    input wire logic                                       i_rst,
    input wire logic                                       i_clk_en,
    input wire lsar_pkg::lsar_host_req_t                   i_host_req,
    input wire logic [lsar_pkg::DATA_W-1:0]                o_host_rdata,
    input wire logic                                       o_host_rvalid,
    input wire logic [NUM_CH-1:0]                          i_alarm,
    input wire logic [lsar_pkg::PIDX_W-1:0]                i_line_sample_idx,
    input wire lsar_pkg::lsar_chan_cfg_t [NUM_CH-1:0]      o_chan_cfg,
    input wire logic [NUM_CH-1:0][lsar_pkg::SAMPLE_W-1:0]  o_line_sample,
    input wire logic                                       o_int_n
);
    import lsar_pkg::*;
    logic [NUM_CH-1:0] highz_v;
    wire               drv_wr = i_clk_en && i_host_req.wr && i_host_req.addr == OFF_DRV_DIS;
    always_comb for (int k = 0; k < NUM_CH; k++) highz_v[k] = o_chan_cfg[k].driver_highz;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // A quiet alarm input means status already equals it, so no new change can be latched.
    sequence quiet;
        i_clk_en && $past(i_clk_en) && !$past(i_rst) && i_alarm == $past(i_alarm);
    endsequence
    sequence alarm_rd(logic [7:0] a);
        i_clk_en && i_host_req.rd && i_host_req.addr == a ##0 quiet;
    endsequence
    chk_rvalid_after_rd: assert property (i_clk_en && i_host_req.rd |=> o_host_rvalid)
        else $error("rvalid missing after read");
    chk_rvalid_only_rd: assert property (i_clk_en && !i_host_req.rd |=> !o_host_rvalid)
        else $error("rvalid without read");
    chk_alarm_mirror: assert property (alarm_rd(OFF_ALM_STAT) |=> o_host_rdata[NUM_CH-1:0] == $past(i_alarm))
        else $error("alarm status differs from alarm input");
    chk_int_clear: assert property (alarm_rd(OFF_ALM_INT) |=> o_int_n)
        else $error("interrupt not released by status read");
    chk_int_cause: assert property ($fell(o_int_n) |-> $past(i_alarm) != $past(i_alarm, 2)
        || $past(i_host_req.wr, 2) || $past(i_rst, 2) || !$past(i_clk_en, 2)) else $error("interrupt without change");
    chk_highz_follows: assert property (drv_wr ##1 (i_clk_en && !drv_wr)
        |=> highz_v == $past(i_host_req.wdata[NUM_CH-1:0], 2)) else $error("driver high-z mismatch");
    chk_reset_clears: assert property ($fell(i_rst) |-> o_chan_cfg == '0 && o_int_n && o_host_rdata == '0)
        else $error("outputs not cleared by reset");
    chk_sample_range: assert property ($past(i_line_sample_idx) >= NUM_SAMPLES && $past(i_clk_en)
        && !$past(i_rst) |-> o_line_sample == '0) else $error("sample beyond range not zero");
endmodule : lsar_regs_properties

bind lsar_regs lsar_regs_properties #(.NUM_CH(NUM_CH), .NUM_SAMPLES(NUM_SAMPLES)) props_u (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_host_req(i_host_req),
    .o_host_rdata(o_host_rdata), .o_host_rvalid(o_host_rvalid), .i_alarm(i_alarm),
    .i_line_sample_idx(i_line_sample_idx), .o_chan_cfg(o_chan_cfg), .o_line_sample(o_line_sample),
    .o_int_n(o_int_n));

// *** lsar_regs_test.sv ***
// Self-checking bench for the line shape and alarm register bank with a host model on its register port.
// Assumes a 200 MHz clock; reset is held for eight cycles and the clock enable stays high except during one frozen write.
`timescale 1ns/1ps
module lsar_regs_test;
    import lsar_pkg::*;
    logic                              i_sys_clk = 1'b0;
    logic                              i_rst = 1'b1;
    logic                              clk_en = 1'b1;
    lsar_host_req_t                    host_req;
    logic [DATA_W-1:0]                 rdata;
    logic                              rvalid;
    logic [CHANNELS-1:0]               alarm = '0;
    logic [PIDX_W-1:0]                 sidx = '0;
    lsar_chan_cfg_t [CHANNELS-1:0]     cfg;
    logic [CHANNELS-1:0][SAMPLE_W-1:0] smp;
    logic                              int_n;
    logic [7:0]                        v, m, en, a;
    logic [2:0]                        c;
    logic [4:0]                        pi;
    integer                            seed = 32'he681_68e9;
    int                                fails = 0;
    int                                check_count = 0;
    lsar_regs dut_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(clk_en), .i_host_req(host_req),
        .o_host_rdata(rdata), .o_host_rvalid(rvalid), .i_alarm(alarm), .i_line_sample_idx(sidx),
        .o_chan_cfg(cfg), .o_line_sample(smp), .o_int_n(int_n));
    lsar_host_model host_u (.i_sys_clk(i_sys_clk), .i_host_rdata(rdata), .i_host_rvalid(rvalid),
        .o_host_req(host_req));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string name);
        logic [7:0] d;
        host_u.rd(addr, d);
        check(name, d, exp);
    endtask : rd_chk
    function automatic lsar_shape_t shape_exp(input logic [3:0] code);
        return (code == 4'h0) ? LSAR_SHAPE_120 : (code == 4'h8) ? LSAR_SHAPE_75 : LSAR_SHAPE_UNDEF;
    endfunction : shape_exp
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic settle();
        repeat (2) @(posedge i_sys_clk);
        #1;
    endtask : settle
    initial forever #2.5 i_sys_clk = ~i_sys_clk;
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fails++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge i_sys_clk);
        #1 i_rst = 1'b0;
        for (int i = 16; i < 24; i++) rd_chk(8'(i), 8'h00, "reset value");
        rd_chk(8'h20, 8'h00, "unmapped read");
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            v = 8'($random(seed));
            v[3:0] = (i == 0) ? 4'h0 : (i == 1) ? 4'h8 : v[3:0];
            c = 3'($random(seed));
            host_u.wr(OFF_SHAPE_CHAN, {5'h00, c});
            host_u.wr(OFF_SHAPE, v);
            rd_chk(OFF_SHAPE, {3'h0, v[4:0]}, "shape readback");
            check("shape decode", 8'(cfg[c].shape), 8'(shape_exp(v[3:0])));
            check("line matching", 8'(cfg[c].internal_matching_select), 8'(v[4]));
        end
        v = 8'($random(seed));
        host_u.wr(OFF_DRV_DIS, v);
        rd_chk(OFF_DRV_DIS, v, "driver disable readback");
        for (int k = 0; k < 8; k++) check("driver high-z", 8'(cfg[k].driver_highz), 8'(v[k]));
        $display("configuration test done");
        en = 8'($random(seed)) | 8'h01;
        a  = 8'($random(seed)) | 8'h01;
        host_u.wr(OFF_ALM_EN, en);
        host_u.wr(OFF_ALM_STAT, 8'hff);
        rd_chk(OFF_ALM_STAT, 8'h00, "status ignores writes");
        alarm = a;
        settle();
        check("interrupt asserted", 8'(int_n), 8'h00);
        rd_chk(OFF_ALM_STAT, a, "alarm status");
        alarm = '0;
        settle();
        rd_chk(OFF_ALM_INT, a & en, "alarm change bits");
        check("interrupt released", 8'(int_n), 8'h01);
        rd_chk(OFF_ALM_INT, 8'h00, "change bits cleared");
        $display("alarm test done");
        // A write taken while the clock enable is low must leave the mask at its reset value.
        clk_en = 1'b0;
        host_u.wr(OFF_BCAST, 8'hff);
        clk_en = 1'b1;
        rd_chk(OFF_BCAST, 8'h00, "frozen write ignored");
        $display("clock enable test done");
        m = 8'($random(seed));
        for (int i = 0; i < 3; i++) begin
            c  = 3'($random(seed));
            pi = (i == 0) ? 5'h00 : (i == 1) ? 5'h17 : 5'($unsigned($random(seed)) % 24);
            v  = (i == 0) ? 8'h3f : (i == 1) ? 8'h40 : {1'b0, 7'($random(seed))};
            m[c] = 1'b1;
            host_u.wr(OFF_BCAST, m);
            host_u.wr(OFF_PHASE_ADDR, {c, pi});
            host_u.wr(OFF_PHASE_DATA, v);
            rd_chk(OFF_PHASE_DATA, v, "phase readback");
            sidx = pi;
            settle();
            for (int k = 0; k < 8; k++) if (m[k]) check("broadcast sample", 8'(smp[k]), v);
        end
        host_u.wr(OFF_BCAST, 8'h00);
        host_u.wr(OFF_PHASE_ADDR, {c, 5'h05});
        host_u.wr(OFF_PHASE_DATA, 8'h2a);
        rd_chk(OFF_PHASE_DATA, 8'h2a, "addressed channel write");
        host_u.wr(OFF_PHASE_ADDR, {c, 5'h18});
        rd_chk(OFF_PHASE_DATA, 8'h00, "phase index beyond range");
        sidx = 5'h18;
        settle();
        check("sample beyond range", 8'(smp[0]), 8'h00);
        $display("waveform test done");
        final_report();
    end
endmodule : lsar_regs_test
